/* design/pbs_port.sv */
// pipelined burst memory port: input capture, burst engine, write queue
`timescale 1ns/1ps
module pbs_port (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // address and command
  input wire logic [pbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic select_low_first_n_i,
  input wire logic select_high_second_i,
  input wire logic select_low_third_n_i,
  input wire logic write_n_i,
  input wire logic [pbs_pkg::LANES-1:0] lane_write_sel_n_i,
  input wire logic advance_or_load_i,
  input wire logic clk_gate_n_i,
  // asynchronous controls and strap
  input wire logic out_en_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_i,
  // data lanes, parity bit is the top bit of each lane
  input wire logic [pbs_pkg::DATA_W-1:0] dq_i,
  output logic [pbs_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // write queue and sleep status
  output logic wq_ready_o,
  output logic sleeping_o
);
  // reset synchroniser
  logic rst_meta_r, rst_sync_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // qualified edge: frozen while the gate is high
  logic run;
  assign run = ~clk_gate_n_i;

  // strap caught once after reset release
  logic order_r, order_nxt, strap_taken_r, strap_taken_nxt;

  always_comb begin
    order_nxt = order_r;
    strap_taken_nxt = 1'b1;
    if (!strap_taken_r) begin
      order_nxt = burst_order_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      order_r <= pbs_pkg::ORDER_INTERLEAVED;
      strap_taken_r <= 1'b0;
    end else begin
      order_r <= order_nxt;
      strap_taken_r <= strap_taken_nxt;
    end
  end

  // burst engine: captured operation, base address, counter and lanes
  pbs_pkg::pbs_op_e op_r, op_nxt;
  logic [pbs_pkg::ADDR_W-1:0] base_r, base_nxt;
  logic [pbs_pkg::BURST_W-1:0] cnt_r, cnt_nxt;
  logic [pbs_pkg::LANES-1:0] lanes_r, lanes_nxt;
  logic selected;

  // all three selects active, sleep blocks new work
  assign selected = ~select_low_first_n_i & select_high_second_i & ~select_low_third_n_i
    & ~sleep_request_i;

  always_comb begin
    op_nxt = op_r;
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    lanes_nxt = lanes_r;
    if (run) begin
      lanes_nxt = ~lane_write_sel_n_i;
      if (advance_or_load_i) begin
        // continue the burst in progress
        case (op_r)
          pbs_pkg::PBS_READ,
          pbs_pkg::PBS_WRITE: begin
            cnt_nxt = cnt_r + pbs_pkg::BURST_ONE;
            if (sleep_request_i) begin
              op_nxt = pbs_pkg::PBS_IDLE;
            end
          end
          pbs_pkg::PBS_IDLE: begin
            op_nxt = pbs_pkg::PBS_IDLE;
          end
          default: begin
            op_nxt = pbs_pkg::PBS_IDLE;
          end
        endcase
      end else if (selected) begin
        // load a new address
        base_nxt = addr_i;
        cnt_nxt = pbs_pkg::BURST_ZERO;
        op_nxt = write_n_i ? pbs_pkg::PBS_READ : pbs_pkg::PBS_WRITE;
      end else begin
        op_nxt = pbs_pkg::PBS_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      op_r <= pbs_pkg::PBS_IDLE;
      base_r <= '0;
      cnt_r <= pbs_pkg::BURST_ZERO;
      lanes_r <= '0;
    end else begin
      op_r <= op_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      lanes_r <= lanes_nxt;
    end
  end

  // effective address inside the four-word burst
  logic [pbs_pkg::BURST_W-1:0] low_addr;
  logic [pbs_pkg::ADDR_W-1:0] eff_addr;

  always_comb begin
    if (order_r == pbs_pkg::ORDER_INTERLEAVED) begin
      low_addr = base_r[pbs_pkg::BURST_W-1:0] ^ cnt_r;
    end else begin
      low_addr = base_r[pbs_pkg::BURST_W-1:0] + cnt_r;
    end
    eff_addr = {base_r[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W], low_addr};
  end

  // read stage: core access now, output register at next qualified edge
  logic rd_launch;
  logic rd_out_r, rd_out_nxt;
  assign rd_launch = run & (op_r == pbs_pkg::PBS_READ);

  always_comb begin
    rd_out_nxt = rd_out_r;
    if (run) begin
      rd_out_nxt = (op_r == pbs_pkg::PBS_READ);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_out_r <= 1'b0;
    end else begin
      rd_out_r <= rd_out_nxt;
    end
  end

  // write pipeline: command, then data sampled two qualified edges later
  pbs_pkg::pbs_wcmd_s wcmd_r, wcmd_nxt;
  pbs_pkg::pbs_wr_s wdat_r, wdat_nxt;
  logic wdat_valid_r, wdat_valid_nxt;
  logic wq_in_ready;

  always_comb begin
    wcmd_nxt = wcmd_r;
    wdat_nxt = wdat_r;
    // a captured word waits here until a qualified edge hands it on
    wdat_valid_nxt = wdat_valid_r;
    if (run) begin
      wcmd_nxt.valid = (op_r == pbs_pkg::PBS_WRITE);
      wcmd_nxt.addr = eff_addr;
      wcmd_nxt.lanes = lanes_r;
      wdat_valid_nxt = wcmd_r.valid;
      wdat_nxt.addr = wcmd_r.addr;
      wdat_nxt.lanes = wcmd_r.lanes;
      wdat_nxt.data = dq_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wcmd_r <= '0;
      wdat_r <= '0;
      wdat_valid_r <= 1'b0;
    end else begin
      wcmd_r <= wcmd_nxt;
      wdat_r <= wdat_nxt;
      wdat_valid_r <= wdat_valid_nxt;
    end
  end

  // write queue between data capture and the array
  pbs_pkg::pbs_wr_s wq_out;
  logic wq_out_valid, wq_drain, wq_push;

  // fill stalls when frozen, so a gated edge moves no word
  assign wq_push = wdat_valid_r & run;
  // drain stalls when frozen or asleep
  assign wq_drain = run & ~sleep_request_i;

  pbs_fifo #(
    .WIDTH($bits(pbs_pkg::pbs_wr_s)),
    .DEPTH(pbs_pkg::FIFO_DEPTH)
  ) u_wq (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_sync_r),
    .in_valid_i(wq_push),
    .in_ready_o(wq_in_ready),
    .in_data_i(wdat_r),
    .out_valid_o(wq_out_valid),
    .out_ready_i(wq_drain),
    .out_data_o(wq_out)
  );

  // array with registered read data as the output register
  pbs_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rd_en_i(rd_launch),
    .rd_addr_i(eff_addr),
    .rd_data_o(dq_o),
    .wr_en_i(wq_out_valid & wq_drain),
    .wr_addr_i(wq_out.addr),
    .wr_lanes_i(wq_out.lanes),
    .wr_data_i(wq_out.data)
  );

  // drivers: pipeline read stage, async enable, off in write data phase
  assign dq_oe_o = rd_out_r & ~out_en_n_i & ~wcmd_r.valid;

  assign wq_ready_o = wq_in_ready;
  assign sleeping_o = sleep_request_i;
endmodule

/* design/pbs_pkg.sv */
// shared constants and carrier types for the pipelined burst memory port
package pbs_pkg;
  // array organisation, wide build
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int MEM_DEPTH = 262144;
  // narrow organisation figures, kept for reference builds
  localparam int NARROW_ADDR_W = 19;
  localparam int NARROW_DATA_W = 18;
  localparam int NARROW_LANES = 2;
  // burst counter width and write data lag behind the command edge
  localparam int BURST_W = 2;
  localparam int WDATA_LAG = 2;
  // write queue depth in words
  localparam int FIFO_DEPTH = 16;
  // burst order strap encoding and its reset value
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

  // operation held by the burst engine
  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_READ,
    PBS_WRITE
  } pbs_op_e;

  // one queued write: address, lane enables (active high), word
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] data;
  } pbs_wr_s;

  // write command waiting for its data phase
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
  } pbs_wcmd_s;
endpackage

/* design/pbs_fifo.sv */
// parameterised valid/ready fifo used as the write queue
`timescale 1ns/1ps
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic full, empty, push, pop;

  // honest full and empty from pointer wrap bit
  assign empty = (wptr_r == rptr_r);
  assign full = (wptr_r[PW] != rptr_r[PW]) && (wptr_r[PW-1:0] == rptr_r[PW-1:0]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign push = in_valid_i & ~full;
  assign pop = out_ready_i & ~empty;
  assign out_data_o = mem_r[rptr_r[PW-1:0]];

  // pointer next values
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (push) begin
      wptr_nxt = wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = rptr_r + 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wptr_r[PW-1:0]] <= in_data_i;
    end
  end
endmodule

/* design/pbs_mem.sv */
// lane-masked storage array with registered read data
`timescale 1ns/1ps
module pbs_mem (
  // clock
  input wire logic clk_sys_i,
  // read port
  input wire logic rd_en_i,
  input wire logic [pbs_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [pbs_pkg::DATA_W-1:0] rd_data_o,
  // write port
  input wire logic wr_en_i,
  input wire logic [pbs_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [pbs_pkg::LANES-1:0] wr_lanes_i,
  input wire logic [pbs_pkg::DATA_W-1:0] wr_data_i
);
  logic [pbs_pkg::DATA_W-1:0] array_r [pbs_pkg::MEM_DEPTH];
  logic [pbs_pkg::DATA_W-1:0] rd_data_r, rd_data_nxt;

  // read register holds unless a read is launched
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (rd_en_i) begin
      rd_data_nxt = array_r[rd_addr_i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rd_data_r <= rd_data_nxt;
  end

  // only selected lanes are written
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      for (int k = 0; k < pbs_pkg::LANES; k++) begin
        if (wr_lanes_i[k]) begin
          array_r[wr_addr_i][k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] <=
            wr_data_i[k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
        end
      end
    end
  end

  assign rd_data_o = rd_data_r;
endmodule

/* testbench/pbs_port_chk.sv */
// pin-level assertions for the pipelined burst memory port
`timescale 1ns/1ps
module pbs_port_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // command pins
  input wire logic select_low_first_n_i,
  input wire logic select_high_second_i,
  input wire logic select_low_third_n_i,
  input wire logic write_n_i,
  input wire logic advance_or_load_i,
  input wire logic clk_gate_n_i,
  input wire logic out_en_n_i,
  input wire logic sleep_request_i,
  // watched outputs
  input wire logic [pbs_pkg::DATA_W-1:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic sleeping_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // qualified edge, load edge, device selected and awake
  wire logic go_w = !clk_gate_n_i;
  wire logic ld_w = go_w && !advance_or_load_i;
  wire logic on_w = !select_low_first_n_i && select_high_second_i
    && !select_low_third_n_i && !sleep_request_i;
  // command then one more qualified edge
  sequence s_rd;
    ld_w && on_w && write_n_i ##1 go_w;
  endsequence
  sequence s_wr;
    ld_w && on_w && !write_n_i ##1 go_w;
  endsequence
  sequence s_off;
    ld_w && !on_w ##1 go_w;
  endsequence
  AST_READ_OE: assert property (s_rd |=> dq_oe_o == !out_en_n_i)
    else $error("read word not driven");
  AST_WRITE_OFF: assert property (s_wr |=> !dq_oe_o)
    else $error("drivers on in write data phase");
  AST_DESEL: assert property (s_off |=> !dq_oe_o)
    else $error("drivers on after deselect");
  AST_SLEEP_LOAD: assert property (ld_w && sleep_request_i ##1 go_w |=> !dq_oe_o)
    else $error("load taken while asleep");
  AST_ADV_IDLE: assert property ((ld_w && !on_w ##1 go_w && advance_or_load_i ##1 go_w)
    |=> !dq_oe_o)
    else $error("advance after deselect drove data");
  AST_BURST_OE: assert property ((ld_w && on_w && write_n_i
    ##1 go_w && advance_or_load_i && !sleep_request_i ##1 go_w)
    |=> dq_oe_o == !out_en_n_i)
    else $error("burst word not driven");
  AST_OE_ASYNC: assert property (out_en_n_i |-> !dq_oe_o)
    else $error("drive with output enable high");
  AST_GATE_DQ: assert property (clk_gate_n_i |=> $stable(dq_o))
    else $error("read data moved on gated edge");
  AST_GATE_OE: assert property (clk_gate_n_i |=> $stable(dq_oe_o) || $changed(out_en_n_i))
    else $error("drive changed on gated edge");
  AST_SLEEP: assert property (sleeping_o == sleep_request_i)
    else $error("sleep status wrong");
endmodule

/* testbench/pbs_ctl_model.sv */
// controller-side model driving write words onto the data lanes
`timescale 1ns/1ps
module pbs_ctl_model (
  // clock
  input wire logic clk_sys_i,
  // write command as taken, and its word
  input wire logic wr_i,
  input wire logic [pbs_pkg::DATA_W-1:0] wd_i,
  // controller drive onto the lanes
  output logic [pbs_pkg::DATA_W-1:0] dq_o
);
  logic v1_r = 1'b0;
  logic v2_r = 1'b0;
  logic [pbs_pkg::DATA_W-1:0] d1_r = '0;
  logic [pbs_pkg::DATA_W-1:0] d2_r = '0;
  // word lags two edges behind its command
  always @(posedge clk_sys_i) begin
    v1_r <= wr_i;
    d1_r <= wd_i;
    v2_r <= v1_r;
    d2_r <= v1_r ? d1_r : d2_r;
  end
  // released lanes show the inverse of the last word
  assign dq_o = v2_r ? d2_r : ~d2_r;
endmodule

/* testbench/pbs_port_bench.sv */
// self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module pbs_port_bench;
  localparam logic [35:0] M = 36'h0_07fc_01ff;
  localparam logic [17:0] A1 = 18'h0_0011;
  localparam logic [17:0] A2 = 18'h0_0022;
  localparam logic [17:0] AB = 18'h0_0104;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [17:0] addr = '0;
  logic [2:0] cs = 3'b000;
  logic wn = 1'b1;
  logic [3:0] lanes = 4'hf;
  logic adv = 1'b0;
  logic gate = 1'b0;
  logic oen = 1'b0;
  logic slp = 1'b0;
  logic order = 1'b1;
  logic wr = 1'b0;
  logic [35:0] wd = '0;
  logic [35:0] dq_i;
  logic [35:0] dq_o;
  logic dq_oe_o;
  logic wq_ready_o;
  logic sleeping_o;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  pbs_port dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .select_low_first_n_i(cs[2]), .select_high_second_i(cs[1]),
    .select_low_third_n_i(cs[0]), .write_n_i(wn), .lane_write_sel_n_i(lanes),
    .advance_or_load_i(adv), .clk_gate_n_i(gate), .out_en_n_i(oen),
    .sleep_request_i(slp), .burst_order_i(order), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .wq_ready_o(wq_ready_o), .sleeping_o(sleeping_o));
  pbs_ctl_model ctl (.clk_sys_i(clk_sys_i), .wr_i(wr), .wd_i(wd), .dq_o(dq_i));
  // clock and hang guard
  initial forever #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [35:0] dat(input logic [17:0] a);
    return {a, ~a};
  endfunction
  // one command at a falling edge, returns at the next one
  task automatic op(input logic a, input logic w, input logic [3:0] l,
    input logic [17:0] ad, input logic [35:0] d);
    adv = a;
    wn = w;
    lanes = l;
    addr = ad;
    wd = d;
    wr = !gate && !a && !w && cs == 3'b010 && !slp;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic idle(input int n);
    cs = 3'b000;
    repeat (n) op(1'b0, 1'b1, 4'hf, '0, '0);
    cs = 3'b010;
  endtask
  task automatic rd(input logic [17:0] ad, input logic [35:0] exp);
    op(1'b0, 1'b1, 4'hf, ad, '0);
    idle(1);
    `CHK(dq_oe_o, 1'b1)
    `CHK(dq_o, exp)
    oen = 1'b1;
    cs = 3'b000;
    #1 `CHK(dq_oe_o, 1'b0)
    @(negedge clk_sys_i);
    oen = 1'b0;
    cs = 3'b010;
  endtask
  task automatic t_word();
    op(1'b0, 1'b0, 4'h0, A1, dat(A1));
    op(1'b0, 1'b0, 4'h0, A2, dat(A2));
    op(1'b0, 1'b1, 4'hf, A1, '0);
    `CHK(wq_ready_o, 1'b1)
    idle(6);
    rd(A1, dat(A1));
    rd(A2, dat(A2));
  endtask
  task automatic t_lane();
    op(1'b0, 1'b0, 4'b1010, A1, 36'hf_ffff_ffff);
    idle(6);
    rd(A1, dat(A1) | M);
  endtask
  task automatic t_burst();
    for (int k = 0; k < 4; k++) op(1'b0, 1'b0, 4'h0, AB + 18'(k), dat(AB + 18'(k)));
    idle(6);
    op(1'b0, 1'b1, 4'hf, AB | 18'h0_0001, '0);
    for (int k = 1; k <= 4; k++) begin
      op(1'b1, 1'b1, 4'hf, '0, '0);
      `CHK(dq_o, dat(AB | 18'(1 ^ (k - 1))))
    end
    idle(1);
  endtask
  task automatic t_gate();
    op(1'b0, 1'b1, 4'hf, A2, '0);
    gate = 1'b1;
    idle(3);
    `CHK(dq_oe_o, 1'b0)
    gate = 1'b0;
    idle(1);
    `CHK(dq_oe_o, 1'b1)
    `CHK(dq_o, dat(A2))
  endtask
  task automatic t_desel();
    for (int k = 0; k < 3; k++) begin
      cs = 3'b010 ^ (3'b001 << k);
      op(1'b0, 1'b1, 4'hf, A1, '0);
      op(1'b1, 1'b1, 4'hf, A1, '0);
      `CHK(dq_oe_o, 1'b0)
      idle(1);
      `CHK(dq_oe_o, 1'b0)
    end
  endtask
  task automatic t_sleep();
    slp = 1'b1;
    op(1'b0, 1'b1, 4'hf, A1, '0);
    `CHK(sleeping_o, 1'b1)
    idle(1);
    `CHK(dq_oe_o, 1'b0)
    slp = 1'b0;
    rd(A1, dat(A1) | M);
    `CHK(sleeping_o, 1'b0)
  endtask
  // mid-run reset with the strap low, then a linear burst over kept data
  task automatic t_linear();
    rst_n_i = 1'b0;
    order = 1'b0;
    cs = 3'b000;
    repeat (2) @(negedge clk_sys_i);
    `CHK(dq_oe_o, 1'b0)
    rst_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    cs = 3'b010;
    op(1'b0, 1'b1, 4'hf, AB | 18'h0_0001, '0);
    for (int k = 1; k <= 4; k++) begin
      op(1'b1, 1'b1, 4'hf, '0, '0);
      `CHK(dq_o, dat(AB | 18'(k % 4)))
    end
    idle(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    cs = 3'b010;
    t_word();
    t_lane();
    t_burst();
    t_gate();
    t_desel();
    t_sleep();
    t_linear();
    wrap_up();
  end
endmodule
bind pbs_port pbs_port_chk chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .select_low_first_n_i(select_low_first_n_i), .select_high_second_i(select_high_second_i),
  .select_low_third_n_i(select_low_third_n_i), .write_n_i(write_n_i),
  .advance_or_load_i(advance_or_load_i), .clk_gate_n_i(clk_gate_n_i),
  .out_en_n_i(out_en_n_i), .sleep_request_i(sleep_request_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .sleeping_o(sleeping_o));
